// *** hw/sec_cfg.svh ***
// offsets, field positions and reset values of the eeprom command port
`ifndef SEC_CFG_SVH
`define SEC_CFG_SVH
`define SEC_REG_OFS       12'h0AC
`define SEC_CMD_HI        29
`define SEC_CMD_LO        28
`define SEC_WID_HI        27
`define SEC_WID_LO        26
`define SEC_BUSY_BIT      25
`define SEC_VLD_BIT       24
`define SEC_LOC_HI        23
`define SEC_LOC_LO        8
`define SEC_DAT_HI        7
`define SEC_DAT_LO        0
`define SEC_CMD_RST       2'h0
`define SEC_WID_RST       2'h0
`define SEC_LOC_RST       16'h0000
`define SEC_DAT_RST       8'h00
`endif

// *** hw/sec_pkg.sv ***
// types of the eeprom command port
package sec_pkg;
  typedef enum logic [1:0] {
    SEC_OP_NONE  = 2'h0,
    SEC_OP_READ  = 2'h1,
    SEC_OP_WRITE = 2'h2,
    SEC_OP_RSVD  = 2'h3
  } sec_op_t;
  typedef enum logic [1:0] {
    SEC_WID_NONE = 2'h0,
    SEC_WID_9    = 2'h1,
    SEC_WID_16   = 2'h2,
    SEC_WID_RSVD = 2'h3
  } sec_wid_t;
  typedef enum logic [1:0] {
    SEC_ST_IDLE = 2'b01,
    SEC_ST_BUSY = 2'b10
  } sec_state_t;
endpackage

// *** hw/sec_cmd_port.sv ***
// eeprom command register and its transfer sequencing
`timescale 1ns/1ps
`include "sec_cfg.svh"

// Behaviour
// RQ1: code 01 starts a read, code 10 starts a write, other codes start nothing.
// RQ2: width field: 00 no eeprom, 01 nine-bit, 10 sixteen-bit addressing.
// RQ3: software writes the width field before any access when it reads 00.
// RQ4: busy bit 25 is read-only, high during a transfer, zero at reset.
// RQ5: software waits for busy clear before writing a new command.
// RQ6: the valid bit 24 must be set for the command to be acted on.
// RQ7: location field 23:8 names the eeprom location, resets to zero.
// RQ8: data field 7:0 holds the byte to write, resets to zero.
// RQ9: busy sets on accepting a command, clears only when the transfer completes.
// RQ10: a finished read places the returned byte in the data field.
module sec_cmd_port
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                core_ce,
  input  wire logic [11:0]         cfg_addr,
  input  wire logic                cfg_we,
  input  wire logic                cfg_re,
  input  wire logic [3:0]          cfg_be,
  input  wire logic [31:0]         cfg_wdata,
  output logic      [31:0]         cfg_rdata,
  output logic                     ee_start,
  output sec_pkg::sec_op_t         ee_op,
  output sec_pkg::sec_wid_t        ee_width,
  output logic      [15:0]         ee_loc,
  output logic      [7:0]          ee_wbyte,
  input  wire logic                ee_done,
  input  wire logic [7:0]          ee_rbyte
);
  import sec_pkg::*;

  sec_op_t    op_r;
  sec_wid_t   wid_r;
  logic       vld_r;
  logic       busy_r;
  logic [15:0] loc_r;
  logic [7:0] dat_r;
  sec_state_t st_r;
  logic       sel_wr;
  logic       accept;
  sec_op_t    op_nxt;
  sec_wid_t   wid_nxt;
  logic       vld_nxt;
  logic [15:0] loc_nxt;
  logic [7:0] dat_nxt;

  // true for a defined operation on a present eeprom
  function automatic logic sec_runnable(input sec_op_t op, input sec_wid_t wid);
    sec_runnable = (op == SEC_OP_READ || op == SEC_OP_WRITE) &&
                   (wid == SEC_WID_9 || wid == SEC_WID_16);
  endfunction

  // register write decode; writes during a transfer are dropped to protect it
  assign sel_wr = core_ce && cfg_we && (cfg_addr == `SEC_REG_OFS) && !busy_r;

  // merge the write into the fields lane by lane
  always_comb
  begin
    op_nxt  = op_r;
    wid_nxt = wid_r;
    vld_nxt = vld_r;
    loc_nxt = loc_r;
    dat_nxt = dat_r;
    if (sel_wr && cfg_be[3])
    begin
      op_nxt  = sec_op_t'(cfg_wdata[`SEC_CMD_HI:`SEC_CMD_LO]);
      wid_nxt = sec_wid_t'(cfg_wdata[`SEC_WID_HI:`SEC_WID_LO]);
      vld_nxt = cfg_wdata[`SEC_VLD_BIT];
    end
    if (sel_wr && cfg_be[2])
      loc_nxt[15:8] = cfg_wdata[`SEC_LOC_HI:16];
    if (sel_wr && cfg_be[1])
      loc_nxt[7:0] = cfg_wdata[15:`SEC_LOC_LO];
    if (sel_wr && cfg_be[0])
      dat_nxt = cfg_wdata[`SEC_DAT_HI:`SEC_DAT_LO];
  end

  // a command starts only when valid and runnable
  assign accept = sel_wr && vld_nxt && sec_runnable(op_nxt, wid_nxt); // [RQ1] [RQ6]

  // command, width, location fields
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_r  <= sec_op_t'(`SEC_CMD_RST);
      wid_r <= sec_wid_t'(`SEC_WID_RST); // [RQ2]
      loc_r <= `SEC_LOC_RST; // [RQ7]
    end
    else if (core_ce)
    begin
      op_r  <= op_nxt;
      wid_r <= wid_nxt; // [RQ2]
      loc_r <= loc_nxt; // [RQ7]
    end
  end

  // data field, loaded from the eeprom when a read finishes
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      dat_r <= `SEC_DAT_RST; // [RQ8]
    else if (core_ce)
    begin
      if (busy_r && ee_done && op_r == SEC_OP_READ)
        dat_r <= ee_rbyte; // [RQ10]
      else
        dat_r <= dat_nxt; // [RQ8]
    end
  end

  // valid bit stays as written and drops when the transfer completes
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      vld_r <= 1'b0;
    else if (core_ce)
    begin
      if (busy_r && ee_done)
        vld_r <= 1'b0;
      else
        vld_r <= vld_nxt; // [RQ6]
    end
  end

  // transfer sequencer
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= SEC_ST_IDLE;
    else if (core_ce)
    begin
      case (st_r)
        SEC_ST_IDLE:
          if (accept)
            st_r <= SEC_ST_BUSY; // [RQ9]
        SEC_ST_BUSY:
          if (ee_done)
            st_r <= SEC_ST_IDLE; // [RQ9]
        default:
          st_r <= SEC_ST_IDLE;
      endcase
    end
  end

  // busy flag mirrors the sequencer
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      busy_r <= 1'b0; // [RQ4]
    else if (core_ce)
    begin
      if (st_r == SEC_ST_IDLE && accept)
        busy_r <= 1'b1; // [RQ4] [RQ9]
      else if (st_r == SEC_ST_BUSY && ee_done)
        busy_r <= 1'b0; // [RQ9]
    end
  end

  // start pulse for the serial engine, one cycle after acceptance
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ee_start <= 1'b0;
    else if (core_ce)
      ee_start <= accept && st_r == SEC_ST_IDLE;
    else
      ee_start <= 1'b0;
  end

  // side-band values held for the serial engine
  assign ee_op    = op_r;
  assign ee_width = wid_r;
  assign ee_loc   = loc_r; // [RQ7]
  assign ee_wbyte = dat_r; // [RQ8]

  // register read, answered on the next edge; busy is read-only
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cfg_rdata <= 32'h0000_0000;
    else if (core_ce)
    begin
      if (cfg_re && cfg_addr == `SEC_REG_OFS)
        cfg_rdata <= {2'h0, op_r, wid_r, busy_r, vld_r, loc_r, dat_r}; // [RQ4]
      else
        cfg_rdata <= 32'h0000_0000;
    end
  end

  // protocol checks on the register and the transfer sequencing
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_start_busy: assert property (accept && st_r == SEC_ST_IDLE |=> busy_r && ee_start) // [RQ9]
    else $error("accepted command did not raise busy and start");
  chk_undef_op: assert property (sel_wr && !sec_runnable(op_nxt, wid_nxt) && core_ce // [RQ1]
    |=> !ee_start)
    else $error("undefined command or absent eeprom started a transfer");
  chk_no_valid: assert property (sel_wr && !vld_nxt |=> !ee_start) // [RQ6]
    else $error("command without valid bit started a transfer");
  chk_busy_hold: assert property (busy_r && !ee_done |=> busy_r) // [RQ4]
    else $error("busy dropped before transfer completed");
  chk_busy_clear: assert property (busy_r && ee_done && core_ce |=> !busy_r) // [RQ9]
    else $error("busy not cleared after completion");
  chk_read_byte: assert property (busy_r && ee_done && core_ce && op_r == SEC_OP_READ // [RQ10]
    |=> dat_r == $past(ee_rbyte))
    else $error("read byte not placed in data field");
  chk_width_kept: assert property (!sel_wr && core_ce |=> wid_r == $past(wid_r)) // [RQ2]
    else $error("width field changed without a write");
  chk_loc_write: assert property (sel_wr && cfg_be[2] && cfg_be[1] // [RQ7]
    |=> ee_loc == $past(cfg_wdata[23:8]))
    else $error("location field not written");
  chk_data_write: assert property (sel_wr && cfg_be[0] && !(busy_r && ee_done) // [RQ8]
    |=> ee_wbyte == $past(cfg_wdata[7:0]))
    else $error("data field not written");
  chk_busy_read: assert property (core_ce && cfg_re && cfg_addr == `SEC_REG_OFS // [RQ4]
    |=> cfg_rdata[25] == $past(busy_r))
    else $error("busy bit reads wrong");

  cov_read_op: cover property (accept && op_nxt == SEC_OP_READ ##[1:20] busy_r && ee_done);
  cov_write_op: cover property (accept && op_nxt == SEC_OP_WRITE ##[1:20] busy_r && ee_done);
  cov_drop_busy: cover property (busy_r && cfg_we && cfg_addr == `SEC_REG_OFS);
endmodule

// *** test/sec_ee_model.sv ***
// behavioural serial eeprom that answers transfer starts after a delay
`timescale 1ns/1ps
module sec_ee_model
(
  input  wire logic        core_clk,
  input  wire logic        ee_start,
  input  wire logic [1:0]  ee_op,
  input  wire logic [15:0] ee_loc,
  input  wire logic [7:0]  ee_wbyte,
  input  wire logic [31:0] lat,
  output logic             ee_done,
  output logic [7:0]       ee_rbyte
);
  logic [7:0] mem [logic [15:0]];
  // one transfer at a time, finished lat cycles after the start pulse
  initial
  begin
    ee_done = 1'b0;
    ee_rbyte = 8'h00;
    forever
    begin
      @(posedge core_clk);
      if (ee_start === 1'b1)
      begin
        repeat (lat) @(posedge core_clk);
        #1;
        if (ee_op == 2'h2)
          mem[ee_loc] = ee_wbyte;
        ee_rbyte = mem.exists(ee_loc) ? mem[ee_loc] : 8'h5A;
        ee_done = 1'b1;
        @(posedge core_clk);
        #1;
        ee_done = 1'b0;
        ee_rbyte = ~ee_rbyte; // released: stale byte must not be reused
      end
    end
  end
endmodule

// *** test/sec_cmd_port_test.sv ***
// self-checking bench of the eeprom command port
`timescale 1ns/1ps
module sec_cmd_port_test;
  import sec_pkg::*;
  logic        core_clk, resetn, core_ce, cfg_we, cfg_re, ee_start, ee_done, rd_pend;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, lat;
  logic [15:0] ee_loc, loc;
  logic [7:0]  ee_wbyte, ee_rbyte, dat;
  sec_op_t     ee_op;
  sec_wid_t    ee_width;
  logic [31:0] rd_q[$], st_q[$];
  integer      seed;
  int          error_cnt, tests_run;
  sec_cmd_port u_dut (.core_clk(core_clk), .resetn(resetn), .core_ce(core_ce),
    .cfg_addr(cfg_addr), .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .ee_start(ee_start), .ee_op(ee_op),
    .ee_width(ee_width), .ee_loc(ee_loc), .ee_wbyte(ee_wbyte), .ee_done(ee_done),
    .ee_rbyte(ee_rbyte));
  sec_ee_model u_ee (.core_clk(core_clk), .ee_start(ee_start), .ee_op(ee_op),
    .ee_loc(ee_loc), .ee_wbyte(ee_wbyte), .lat(lat), .ee_done(ee_done), .ee_rbyte(ee_rbyte));
  // clock of 25 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // register access, one strobe cycle each
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge core_clk);
    cfg_we = 1'b1; cfg_addr = a; cfg_wdata = d;
    @(negedge core_clk);
    cfg_we = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(negedge core_clk);
    cfg_re = 1'b1; cfg_addr = a;
    @(negedge core_clk);
    cfg_re = 1'b0;
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 50 && ee_done !== 1'b1; n++) @(negedge core_clk);
    if (n == 50)
    begin
      error_cnt++;
      conclude();
    end
    else
      @(negedge core_clk);
  endtask
  // issue a command; rb is the data field expected after completion
  task automatic cmd(input logic [1:0] op, input logic [1:0] wid, input logic vld,
                     input logic [7:0] d, input logic [7:0] rb);
    logic [31:0] w;
    logic        go;
    w = {2'h0, op, wid, 1'b0, vld, loc, d};
    go = vld & (op == 2'h1 | op == 2'h2) & (wid == 2'h1 | wid == 2'h2);
    lat = ($random(seed) & 32'h7) + 3; // keeps busy up through the readback
    if (go) st_q.push_back({4'h0, op, wid, loc, d});
    wr(12'h0AC, w);
    if (go)
    begin
      wr(12'h0AC, ~w);
      rd(12'h0AC, w | 32'h0200_0000);
      wait_done();
      w = {2'h0, op, wid, 2'h0, loc, rb};
    end
    rd(12'h0AC, w);
  endtask
  // monitor: compare read data and start pulses with the oldest notes
  always @(posedge core_clk) rd_pend <= cfg_re;
  always @(negedge core_clk)
  begin
    if (rd_pend === 1'b1)
      check(cfg_rdata, rd_q.pop_front());
    if (ee_start === 1'b1)
      check({4'h0, ee_op, ee_width, ee_loc, ee_wbyte}, st_q.pop_front());
  end
  // main sequence
  initial
  begin
    seed = 32'h0E2C2BC8;
    error_cnt = 0; tests_run = 0; lat = 3;
    resetn = 1'b0; core_ce = 1'b1; cfg_we = 1'b0; cfg_re = 1'b0;
    cfg_addr = 12'h000; cfg_be = 4'hF; cfg_wdata = 32'h0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    rd(12'h0AC, 32'h0);
    loc = 16'($random(seed));
    dat = 8'($random(seed));
    cmd(2'h2, 2'h1, 1'b1, dat, dat);
    cmd(2'h1, 2'h2, 1'b1, ~dat, dat);
    cmd(2'h0, 2'h1, 1'b1, dat, 8'h00);
    cmd(2'h3, 2'h2, 1'b1, dat, 8'h00);
    cmd(2'h1, 2'h1, 1'b0, dat, 8'h00);
    cmd(2'h1, 2'h0, 1'b1, dat, 8'h00);
    // a write with the clock enable low must leave every field frozen
    core_ce = 1'b0;
    wr(12'h0AC, 32'hFFFF_FFFF);
    core_ce = 1'b1;
    rd(12'h0AC, {8'h11, loc, dat});
    wr(12'h0B0, 32'hFFFF_FFFF);
    rd(12'h0B0, 32'h0);
    repeat (3) @(negedge core_clk);
    check(rd_q.size() + st_q.size(), 32'h0);
    conclude();
  end
endmodule
